// File: rtl/bscu_pkg.sv
// Package of types and constants for the branch, skip and call unit
package bscu_pkg;

  localparam int PC_W = 16;

  // Status register bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // Cycle counts, acceptance cycle included
  localparam logic [2:0] CYC_BASE      = 3'h1;
  localparam logic [2:0] CYC_PTR_CALL  = 3'h3;
  localparam logic [2:0] CYC_INT_RET   = 3'h4;
  localparam logic [2:0] CYC_BR_TAKEN  = 3'h2;
  localparam logic [2:0] CYC_SKIP_ONE  = 3'h2;
  localparam logic [2:0] CYC_SKIP_TWO  = 3'h3;
  localparam logic [2:0] CYC_HOLD_BIAS = 3'h2;

  // Program counter steps
  localparam logic [PC_W-1:0] PC_STEP_NEXT     = 16'h0001;
  localparam logic [PC_W-1:0] PC_STEP_SKIP_ONE = 16'h0002;
  localparam logic [PC_W-1:0] PC_STEP_SKIP_TWO = 16'h0003;

  typedef enum logic [4:0] {
    NO_OP                     = 5'h00,
    POINTER_CALL_OP           = 5'h01,
    INTERRUPT_RETURN_OP       = 5'h02,
    EQUAL_SKIP_OP             = 5'h03,
    REG_COMPARE_OP            = 5'h04,
    CARRY_COMPARE_OP          = 5'h05,
    IMMEDIATE_COMPARE_OP      = 5'h06,
    REGBIT_ZERO_SKIP_OP       = 5'h07,
    REGBIT_ONE_SKIP_OP        = 5'h08,
    IOBIT_ZERO_SKIP_OP        = 5'h09,
    IOBIT_ONE_SKIP_OP         = 5'h0A,
    FLAG_SET_BRANCH_OP        = 5'h0B,
    FLAG_CLEAR_BRANCH_OP      = 5'h0C,
    CARRY_CLEAR_BRANCH_OP     = 5'h0D,
    UNSIGNED_GE_BRANCH_OP     = 5'h0E,
    SIGNED_GE_BRANCH_OP       = 5'h0F,
    SIGNED_LT_BRANCH_OP       = 5'h10,
    HALFCARRY_SET_BRANCH_OP   = 5'h11,
    HALFCARRY_CLEAR_BRANCH_OP = 5'h12,
    USER_BIT_SET_BRANCH_OP    = 5'h13,
    USER_BIT_CLEAR_BRANCH_OP  = 5'h14,
    OVERFLOW_SET_BRANCH_OP    = 5'h15,
    OVERFLOW_CLEAR_BRANCH_OP  = 5'h16
  } bscu_op_t;

  typedef struct packed {
    bscu_op_t        op;
    logic [PC_W-1:0] pc;
    logic [7:0]      reg_d;
    logic [7:0]      reg_r;
    logic [7:0]      imm;
    logic [2:0]      bit_sel;
    logic [7:0]      io_val;
    logic [6:0]      offset;
    logic            next_two_word;
    logic [PC_W-1:0] z_ptr;
  } bscu_instr_t;

  typedef struct packed {
    logic            load;
    logic [PC_W-1:0] target;
  } bscu_redirect_t;

  typedef struct packed {
    logic            push;
    logic            pop;
    logic [PC_W-1:0] data;
  } bscu_stack_t;

  typedef struct packed {
    logic h;
    logic s;
    logic v;
    logic n;
    logic z;
    logic c;
  } bscu_flags_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_HOLD = 2'b10
  } bscu_state_e_t;

  typedef struct packed {
    bscu_state_e_t   st;
    logic [1:0]      cnt;
    logic            ready;
    logic            done;
    logic            pend_load;
    logic            pend_interrupt_return_op;
    logic            pop_wait;
    bscu_redirect_t  redir;
    logic [PC_W-1:0] tgt;
    logic            status_register_we;
    logic [7:0]      status_register_val;
    bscu_stack_t     stk;
  } bscu_state_t;

  localparam bscu_state_t STATE_RST = '{
    st:        ST_IDLE,
    cnt:       2'h0,
    ready:     1'b1,
    done:      1'b0,
    pend_load: 1'b0,
    pend_interrupt_return_op: 1'b0,
    pop_wait:  1'b0,
    redir:     '{load: 1'b0, target: 16'h0000},
    tgt:       16'h0000,
    status_register_we:   1'b0,
    status_register_val:  8'h00,
    stk:       '{push: 1'b0, pop: 1'b0, data: 16'h0000}
  };

endpackage

// File: rtl/bscu_sub_flags.sv
// Flag generator for an 8-bit subtract whose result is discarded
`timescale 1ns/1ns
module bscu_sub_flags (
  input  wire logic [7:0]           a,
  input  wire logic [7:0]           b,
  input  wire logic                 cin,
  output      bscu_pkg::bscu_flags_t flags
);

  logic [8:0] diff;

  assign diff = {1'b0, a} - {1'b0, b} - {8'h00, cin};

  always_comb
  begin
    flags.c = diff[8];
    flags.n = diff[7];
    flags.z = (diff[7:0] == 8'h00);
    flags.h = (~a[3] & b[3]) | (b[3] & diff[3]) | (diff[3] & ~a[3]);
    flags.v = (a[7] & ~b[7] & ~diff[7]) | (~a[7] & b[7] & diff[7]);
    flags.s = flags.n ^ flags.v;
  end

endmodule // bscu_sub_flags

// File: rtl/bscu_core.sv
// Branch, skip and call execution unit of the 8-bit core
`timescale 1ns/1ns
// Function
// - Pointer call loads Z, 3 cycles, flags kept
// - Equal registers skip next, 1/2/3 cycles
// - Immediate compare sets Z,N,V,C,H in 1 cycle
// - Register bit zero skips next, 1/2/3 cycles
// - Register bit one skips, advance 2 or 3
// - I/O bit zero skips next, 1/2/3 cycles
// - I/O bit one skips, flags unchanged
// - Selected flag set branches, 1/2 cycles
// - Selected flag clear branches, else 1 cycle
// - Carry clear branches, taken costs 2 cycles
// - Same-or-higher shares carry clear condition
// - Branch when N xor V is 0
// - Branch when N xor V is 1
// - Half carry set branches to PC+k+1
// - Half carry clear branches, else 1 cycle
// - Transfer flag set branches
// - Transfer flag clear branches
// - Overflow set branches, flags unchanged
// - Overflow clear branches to PC+k+1
module bscu_core (
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  input  wire logic                        instr_valid,
  input  wire bscu_pkg::bscu_instr_t       instr,
  input  wire logic [7:0]                  status_register_in,
  input  wire logic [bscu_pkg::PC_W-1:0]   pop_data,
  output      logic                        instr_ready,
  output      logic                        done,
  output      bscu_pkg::bscu_redirect_t    redirect,
  output      logic                        status_register_we,
  output      logic [7:0]                  status_register_wdata,
  output      bscu_pkg::bscu_stack_t       stack
);

  bscu_pkg::bscu_state_t s_r;
  bscu_pkg::bscu_state_t s_nxt;

  bscu_pkg::bscu_flags_t cmp_flags;
  logic [7:0]            cmp_rhs;
  logic                  cmp_cin;
  logic                  flag_sel;
  logic                  sign_lt;
  logic                  reg_bit;
  logic                  io_bit;

  // Compare with immediate uses the constant in place of the second register
  assign cmp_rhs = (instr.op == bscu_pkg::IMMEDIATE_COMPARE_OP) ? instr.imm : instr.reg_r;
  assign cmp_cin = (instr.op == bscu_pkg::CARRY_COMPARE_OP) ? status_register_in[bscu_pkg::FLAG_C] : 1'b0;

  bscu_sub_flags u_sub_flags (
    .a     (instr.reg_d),
    .b     (cmp_rhs),
    .cin   (cmp_cin),
    .flags (cmp_flags)
  );

  assign flag_sel = status_register_in[instr.bit_sel];
  assign sign_lt  = status_register_in[bscu_pkg::FLAG_N] ^ status_register_in[bscu_pkg::FLAG_V];
  assign reg_bit  = instr.reg_r[instr.bit_sel];
  assign io_bit   = instr.io_val[instr.bit_sel];

  always_comb
  begin
    logic [2:0]                ncyc;
    logic                      take;
    logic                      is_skip;
    logic                      is_branch;
    logic                      redir;
    logic [bscu_pkg::PC_W-1:0] tgt;
    logic [bscu_pkg::PC_W-1:0] rel;
    logic [7:0]                sv;
    ncyc      = bscu_pkg::CYC_BASE;
    take      = 1'b0;
    is_skip   = 1'b0;
    is_branch = 1'b0;
    redir     = 1'b0;
    tgt       = instr.pc;
    rel       = {{9{instr.offset[6]}}, instr.offset};
    sv        = status_register_in;
    s_nxt     = s_r;
    s_nxt.done       = 1'b0;
    s_nxt.redir.load = 1'b0;
    s_nxt.status_register_we    = 1'b0;
    s_nxt.stk.push   = 1'b0;
    s_nxt.stk.pop    = 1'b0;
    unique case (s_r.st)
      bscu_pkg::ST_IDLE:
      begin
        if (instr_valid)
        begin
          unique case (instr.op)
            bscu_pkg::POINTER_CALL_OP:
            begin
              ncyc  = bscu_pkg::CYC_PTR_CALL;
              redir = 1'b1;
              tgt   = instr.z_ptr;
              // Return address leaves before the target is loaded
              s_nxt.stk.push = 1'b1;
              s_nxt.stk.data = instr.pc + bscu_pkg::PC_STEP_NEXT;
            end
            bscu_pkg::INTERRUPT_RETURN_OP:
            begin
              ncyc  = bscu_pkg::CYC_INT_RET;
              redir = 1'b1;
              s_nxt.stk.pop = 1'b1;
              s_nxt.pop_wait = 1'b1;
            end
            bscu_pkg::EQUAL_SKIP_OP:
            begin
              is_skip = 1'b1;
              take    = (instr.reg_d == instr.reg_r);
            end
            bscu_pkg::REG_COMPARE_OP,
            bscu_pkg::CARRY_COMPARE_OP,
            bscu_pkg::IMMEDIATE_COMPARE_OP:
            begin
              // Result is discarded; only the flags are written back
              s_nxt.status_register_we = 1'b1;
              sv[bscu_pkg::FLAG_C] = cmp_flags.c;
              sv[bscu_pkg::FLAG_N] = cmp_flags.n;
              sv[bscu_pkg::FLAG_V] = cmp_flags.v;
              sv[bscu_pkg::FLAG_H] = cmp_flags.h;
              // Carry compare may only keep zero, for multi-byte chains
              if (instr.op == bscu_pkg::CARRY_COMPARE_OP)
              begin
                sv[bscu_pkg::FLAG_Z] = cmp_flags.z & status_register_in[bscu_pkg::FLAG_Z];
              end
              else
              begin
                sv[bscu_pkg::FLAG_Z] = cmp_flags.z;
              end
            end
            bscu_pkg::REGBIT_ZERO_SKIP_OP:
            begin
              is_skip = 1'b1;
              take    = ~reg_bit;
            end
            bscu_pkg::REGBIT_ONE_SKIP_OP:
            begin
              is_skip = 1'b1;
              take    = reg_bit;
            end
            bscu_pkg::IOBIT_ZERO_SKIP_OP:
            begin
              is_skip = 1'b1;
              take    = ~io_bit;
            end
            bscu_pkg::IOBIT_ONE_SKIP_OP:
            begin
              is_skip = 1'b1;
              take    = io_bit;
            end
            bscu_pkg::FLAG_SET_BRANCH_OP:
            begin
              is_branch = 1'b1;
              take      = flag_sel;
            end
            bscu_pkg::FLAG_CLEAR_BRANCH_OP:
            begin
              is_branch = 1'b1;
              take      = ~flag_sel;
            end
            bscu_pkg::CARRY_CLEAR_BRANCH_OP:
            begin
              is_branch = 1'b1;
              take      = ~status_register_in[bscu_pkg::FLAG_C];
            end
            bscu_pkg::UNSIGNED_GE_BRANCH_OP:
            begin
              is_branch = 1'b1;
              take      = ~status_register_in[bscu_pkg::FLAG_C];
            end
            bscu_pkg::SIGNED_GE_BRANCH_OP:
            begin
              is_branch = 1'b1;
              // N xor V is used, not the stored sign bit, which may be stale
              take      = ~sign_lt;
            end
            bscu_pkg::SIGNED_LT_BRANCH_OP:
            begin
              is_branch = 1'b1;
              take      = sign_lt;
            end
            bscu_pkg::HALFCARRY_SET_BRANCH_OP:
            begin
              is_branch = 1'b1;
              take      = status_register_in[bscu_pkg::FLAG_H];
            end
            bscu_pkg::HALFCARRY_CLEAR_BRANCH_OP:
            begin
              is_branch = 1'b1;
              take      = ~status_register_in[bscu_pkg::FLAG_H];
            end
            bscu_pkg::USER_BIT_SET_BRANCH_OP:
            begin
              is_branch = 1'b1;
              take      = status_register_in[bscu_pkg::FLAG_T];
            end
            bscu_pkg::USER_BIT_CLEAR_BRANCH_OP:
            begin
              is_branch = 1'b1;
              take      = ~status_register_in[bscu_pkg::FLAG_T];
            end
            bscu_pkg::OVERFLOW_SET_BRANCH_OP:
            begin
              is_branch = 1'b1;
              take      = status_register_in[bscu_pkg::FLAG_V];
            end
            bscu_pkg::OVERFLOW_CLEAR_BRANCH_OP:
            begin
              is_branch = 1'b1;
              take      = ~status_register_in[bscu_pkg::FLAG_V];
            end
            default:
            begin
              // Unknown codes retire in one cycle with no effect
              ncyc = bscu_pkg::CYC_BASE;
            end
          endcase
          if (is_skip && take)
          begin
            redir = 1'b1;
            if (instr.next_two_word)
            begin
              ncyc = bscu_pkg::CYC_SKIP_TWO;
              tgt  = instr.pc + bscu_pkg::PC_STEP_SKIP_TWO;
            end
            else
            begin
              ncyc = bscu_pkg::CYC_SKIP_ONE;
              tgt  = instr.pc + bscu_pkg::PC_STEP_SKIP_ONE;
            end
          end
          if (is_branch && take)
          begin
            redir = 1'b1;
            ncyc  = bscu_pkg::CYC_BR_TAKEN;
            tgt   = instr.pc + rel + bscu_pkg::PC_STEP_NEXT;
          end
          s_nxt.status_register_val = sv;
          if (ncyc == bscu_pkg::CYC_BASE)
          begin
            s_nxt.done         = 1'b1;
            s_nxt.redir.load   = redir;
            s_nxt.redir.target = tgt;
          end
          else
          begin
            // Fetch is held off until the last cycle of the instruction
            s_nxt.st        = bscu_pkg::ST_HOLD;
            s_nxt.ready     = 1'b0;
            s_nxt.cnt       = 2'(ncyc - bscu_pkg::CYC_HOLD_BIAS);
            s_nxt.pend_load = redir;
            s_nxt.pend_interrupt_return_op = (instr.op == bscu_pkg::INTERRUPT_RETURN_OP);
            s_nxt.tgt       = tgt;
          end
        end
      end
      bscu_pkg::ST_HOLD:
      begin
        // Stack data is taken in the same cycle as the pop strobe
        if (s_r.pop_wait)
        begin
          s_nxt.tgt      = pop_data;
          s_nxt.pop_wait = 1'b0;
        end
        if (s_r.cnt == 2'h0)
        begin
          s_nxt.st           = bscu_pkg::ST_IDLE;
          s_nxt.ready        = 1'b1;
          s_nxt.done         = 1'b1;
          s_nxt.redir.load   = s_r.pend_load;
          s_nxt.redir.target = s_r.tgt;
          if (s_r.pend_interrupt_return_op)
          begin
            // Flags are taken at retirement so earlier writers are not lost
            s_nxt.status_register_we  = 1'b1;
            s_nxt.status_register_val = status_register_in | (8'h01 << bscu_pkg::FLAG_I);
          end
        end
        else
        begin
          s_nxt.cnt = s_r.cnt - 2'h1;
        end
      end
      default:
      begin
        s_nxt = bscu_pkg::STATE_RST;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      s_r <= bscu_pkg::STATE_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign instr_ready = s_r.ready;
  assign done        = s_r.done;
  assign redirect    = s_r.redir;
  assign status_register_we     = s_r.status_register_we;
  assign status_register_wdata  = s_r.status_register_val;
  assign stack       = s_r.stk;

endmodule // bscu_core

// File: verification/bscu_core_monitor.sv
// Port checker of the branch, skip and call unit
`timescale 1ns/1ns
module bscu_core_monitor (
  input wire logic                      mclk,
  input wire logic                      rst_n,
  input wire logic                      instr_valid,
  input wire bscu_pkg::bscu_instr_t     instr,
  input wire logic [7:0]                status_register_in,
  input wire logic [bscu_pkg::PC_W-1:0] pop_data,
  input wire logic                      instr_ready,
  input wire logic                      done,
  input wire bscu_pkg::bscu_redirect_t  redirect,
  input wire logic                      status_register_we,
  input wire logic [7:0]                status_register_wdata,
  input wire bscu_pkg::bscu_stack_t     stack
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic        take;
  logic [15:0] br_tgt_r;
  logic [15:0] skp_tgt_r;
  assign take = instr_valid && instr_ready;
  // Latched at acceptance, the fields may move on afterwards
  always_ff @(posedge mclk)
  begin
    if (take)
    begin
      br_tgt_r  <= instr.pc + {{9{instr.offset[6]}}, instr.offset} + 16'h0001;
      skp_tgt_r <= instr.pc + (instr.next_two_word ? 16'h0003 : 16'h0002);
    end
  end
  sequence s_call_take;
    take && instr.op == bscu_pkg::POINTER_CALL_OP;
  endsequence
  sequence s_call_end;
    done && redirect.load && redirect.target == $past(instr.z_ptr, 3);
  endsequence
  chk_call_push: assert property (
    s_call_take |=> stack.push && stack.data == $past(instr.pc) + 16'h0001)
    else $error("pointer call did not push pc plus one");
  chk_call_end: assert property (s_call_take |-> ##3 s_call_end)
    else $error("pointer call did not load pointer after 3 cycles");
  chk_call_busy: assert property (
    s_call_take |=> !instr_ready [*2] ##1 instr_ready)
    else $error("pointer call busy window wrong");
  chk_call_flags: assert property (s_call_take |=> !status_register_we [*3])
    else $error("pointer call wrote status");
  chk_cmp_flags: assert property (
    take && instr.op == bscu_pkg::IMMEDIATE_COMPARE_OP |=> done && status_register_we && !redirect.load)
    else $error("immediate compare flags not in 1 cycle");
  chk_branch_fall: assert property (
    take && instr.op == bscu_pkg::FLAG_SET_BRANCH_OP && !status_register_in[instr.bit_sel]
    |=> done && !redirect.load)
    else $error("untaken branch not retired in 1 cycle");
  chk_branch_taken: assert property (
    take && instr.op == bscu_pkg::FLAG_SET_BRANCH_OP && status_register_in[instr.bit_sel]
    |=> !done ##1 (done && redirect.load && redirect.target == br_tgt_r))
    else $error("taken branch wrong target or timing");
  chk_skip_two: assert property (
    take && instr.op == bscu_pkg::EQUAL_SKIP_OP && instr.reg_d == instr.reg_r
    && instr.next_two_word |=> !done [*2] ##1 (done && redirect.target == skp_tgt_r))
    else $error("two-word skip wrong");
  chk_io_flags: assert property (
    take && instr.op == bscu_pkg::IOBIT_ONE_SKIP_OP |=> !status_register_we)
    else $error("io bit skip wrote status");
endmodule // bscu_core_monitor

bind bscu_core bscu_core_monitor u_mon (
  .mclk(mclk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
  .status_register_in(status_register_in), .pop_data(pop_data), .instr_ready(instr_ready), .done(done),
  .redirect(redirect), .status_register_we(status_register_we), .status_register_wdata(status_register_wdata), .stack(stack)
);

// File: verification/bscu_fetch_model.sv
// Return stack model on the fetch side of the unit
`timescale 1ns/1ns
module bscu_fetch_model (
  input wire logic                      mclk,
  input wire bscu_pkg::bscu_stack_t     stack,
  output     logic [bscu_pkg::PC_W-1:0] pop_data
);
  logic [15:0] mem [0:7];
  logic [2:0]  sp_r = 3'h0;
  logic        hold_r = 1'b0;
  logic [15:0] junk_r = 16'h5A3C;
  always @(posedge mclk)
  begin
    hold_r <= stack.pop === 1'b1;
    junk_r <= ~junk_r;
    if (stack.push === 1'b1)
    begin
      mem[sp_r] <= stack.data;
      sp_r      <= sp_r + 3'h1;
    end
    if (stack.pop === 1'b1)
      sp_r <= sp_r - 3'h1;
  end
  // For one cycle after the pop the word is held, then it toggles, so a later capture shows
  assign pop_data = (stack.pop === 1'b1) ? mem[sp_r - 3'h1] : hold_r ? mem[sp_r] : junk_r;
endmodule // bscu_fetch_model

// File: verification/bscu_core_tb_top.sv
// Self-checking bench of the branch, skip and call unit
`timescale 1ns/1ns
module bscu_core_tb_top;
  logic                      mclk = 1'b0;
  logic                      rst_n = 1'b0;
  logic                      instr_valid = 1'b0;
  bscu_pkg::bscu_instr_t     instr = '0;
  logic [7:0]                status_register_in = 8'h00;
  logic [bscu_pkg::PC_W-1:0] pop_data;
  logic                      instr_ready;
  logic                      done;
  bscu_pkg::bscu_redirect_t  redirect;
  logic                      status_register_we;
  logic [7:0]                status_register_wdata;
  bscu_pkg::bscu_stack_t     stack;
  int                        mismatches = 0;
  int                        checks = 0;
  logic [15:0]               n, tg, pd;
  logic [7:0]                wd;
  logic                      ld, we, pu;
  always #4 mclk = ~mclk;
  bscu_core uut (
    .mclk(mclk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
    .status_register_in(status_register_in), .pop_data(pop_data), .instr_ready(instr_ready), .done(done),
    .redirect(redirect), .status_register_we(status_register_we), .status_register_wdata(status_register_wdata), .stack(stack)
  );
  bscu_fetch_model u_fetch (.mclk(mclk), .stack(stack), .pop_data(pop_data));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Offers one instruction, counts cycles up to done
  task automatic exec(input bscu_pkg::bscu_instr_t i, input logic [7:0] s);
    @(posedge mclk);
    instr <= i;
    status_register_in <= s;
    instr_valid <= 1'b1;
    @(posedge mclk);
    instr_valid <= 1'b0;
    n = 16'h0000;
    pu = 1'b0;
    do
    begin
      #1;
      n = n + 16'h0001;
      if (stack.push === 1'b1)
      begin
        pu = 1'b1;
        pd = stack.data;
      end
      if (done !== 1'b1)
        @(posedge mclk);
    end while (done !== 1'b1 && n < 16'h0008);
    if (done !== 1'b1)
    begin
      mismatches++;
      complete_run();
    end
    {ld, tg, we, wd} = {redirect.load, redirect.target, status_register_we, status_register_wdata};
  endtask
  function automatic logic cond(input bscu_pkg::bscu_op_t op, input logic [7:0] s,
                                input logic [2:0] b);
    case (op)
      bscu_pkg::FLAG_SET_BRANCH_OP:        return s[b];
      bscu_pkg::FLAG_CLEAR_BRANCH_OP:      return !s[b];
      bscu_pkg::CARRY_CLEAR_BRANCH_OP,
      bscu_pkg::UNSIGNED_GE_BRANCH_OP:     return !s[bscu_pkg::FLAG_C];
      bscu_pkg::SIGNED_GE_BRANCH_OP:       return !(s[bscu_pkg::FLAG_N] ^ s[bscu_pkg::FLAG_V]);
      bscu_pkg::SIGNED_LT_BRANCH_OP:       return s[bscu_pkg::FLAG_N] ^ s[bscu_pkg::FLAG_V];
      bscu_pkg::HALFCARRY_SET_BRANCH_OP:   return s[bscu_pkg::FLAG_H];
      bscu_pkg::HALFCARRY_CLEAR_BRANCH_OP: return !s[bscu_pkg::FLAG_H];
      bscu_pkg::USER_BIT_SET_BRANCH_OP:    return s[bscu_pkg::FLAG_T];
      bscu_pkg::USER_BIT_CLEAR_BRANCH_OP:  return !s[bscu_pkg::FLAG_T];
      bscu_pkg::OVERFLOW_SET_BRANCH_OP:    return s[bscu_pkg::FLAG_V];
      default:                             return !s[bscu_pkg::FLAG_V];
    endcase
  endfunction
  task automatic t_call_return();
    bscu_pkg::bscu_instr_t i;
    i = '0;
    i.op = bscu_pkg::POINTER_CALL_OP;
    i.pc = 16'h1234;
    i.z_ptr = 16'h4C80;
    exec(i, 8'h3F);
    cmp(n, 16'h0003);
    cmp({13'h0000, ld, we, pu}, 16'h0005);
    cmp(tg, 16'h4C80);
    cmp(pd, 16'h1235);
    i.op = bscu_pkg::INTERRUPT_RETURN_OP;
    exec(i, 8'h15);
    cmp(n, 16'h0004);
    cmp({8'h00, wd}, 16'h0095);
    cmp(tg, 16'h1235);
  endtask
  task automatic t_skips();
    bscu_pkg::bscu_instr_t i;
    logic                  hit;
    logic [7:0]            v;
    logic [15:0]           adv;
    for (int o = 3; o <= 10; o++)
      for (int c = 0; c < 4; c++)
      begin
        if (o > 3 && o < 7)
          continue;
        i = '0;
        i.op = bscu_pkg::bscu_op_t'(o[4:0]);
        i.pc = 16'h0200 + 16'(o);
        i.bit_sel = 3'(o + c);
        i.next_two_word = c[1];
        hit = c[0];
        // Zero-sense skips want the selected bit low
        v = (8'h01 << i.bit_sel) ^ (((o == 7 || o == 9) ^ hit) ? 8'h00 : 8'hFF);
        {i.reg_d, i.reg_r, i.io_val} = {v, v, v};
        if (o == 3)
          i.reg_r = hit ? i.reg_d : ~i.reg_d;
        adv = c[1] ? 16'h0003 : 16'h0002;
        exec(i, 8'hC3);
        cmp(n, hit ? adv : 16'h0001);
        cmp({14'h0000, ld, we}, {14'h0000, hit, 1'b0});
        if (hit)
          cmp(tg, i.pc + adv);
      end
  endtask
  task automatic t_branches();
    bscu_pkg::bscu_instr_t i;
    logic                  hit;
    logic [7:0]            pat [8] = '{8'h00, 8'hFF, 8'h01, 8'h04, 8'h08, 8'h20, 8'h40, 8'h0C};
    for (int o = 11; o <= 22; o++)
      for (int j = 0; j < 8; j++)
      begin
        i = '0;
        i.op = bscu_pkg::bscu_op_t'(o[4:0]);
        i.pc = 16'h0800;
        i.bit_sel = 3'(j + o);
        i.offset = j[0] ? 7'h40 : 7'h05;
        hit = cond(i.op, pat[j], i.bit_sel);
        exec(i, pat[j]);
        cmp(n, hit ? 16'h0002 : 16'h0001);
        cmp({15'h0000, ld}, {15'h0000, hit});
        if (hit)
          cmp(tg, i.pc + {{9{i.offset[6]}}, i.offset} + 16'h0001);
      end
  endtask
  task automatic t_compare();
    bscu_pkg::bscu_instr_t i;
    logic [7:0]            a, b, r, s;
    logic [15:0]           v [5] = '{16'h1010, 16'h0001, 16'h8001, 16'h7FFF, 16'h2318};
    for (int j = 0; j < 5; j++)
    begin
      {a, b} = v[j];
      r = a - b;
      s = j[0] ? 8'hAA : 8'h55;
      i = '0;
      i.op = bscu_pkg::IMMEDIATE_COMPARE_OP;
      {i.reg_d, i.imm, i.reg_r} = {a, b, ~b};
      exec(i, s);
      cmp({n[13:0], we, ld}, 16'h0006);
      cmp({8'h00, wd}, {8'h00, s[7:6], (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]), s[4],
          (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]), r[7], r == 8'h00, a < b});
    end
    // Carry compare keeps zero only when it was already set
    i.op = bscu_pkg::CARRY_COMPARE_OP;
    {i.reg_d, i.reg_r} = 16'h100F;
    exec(i, 8'h03);
    cmp({8'h00, wd}, 16'h0022);
    i.op = bscu_pkg::REG_COMPARE_OP;
    exec(i, 8'h00);
    cmp({8'h00, wd}, 16'h0020);
    // Unknown code retires in one cycle, no write, no redirect
    i.op = bscu_pkg::NO_OP;
    exec(i, 8'h00);
    cmp({n[13:0], we, ld}, 16'h0004);
  endtask
  initial
  begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    t_call_return();
    t_skips();
    t_branches();
    t_compare();
    complete_run();
  end
endmodule // bscu_core_tb_top
